/* File: rtl/islp_pkg.sv */
// Package of constants and carrier types for the interrupt service and low-power block
// Summary of operation
// - Highest-level pending request is served first; daisy-chain position breaks ties.
// - Entering service sets all three mask level bits, blocking every maskable request.
// - A running non-maskable routine blocks further non-maskable requests until return.
// - Return pops the saved status word, restoring the earlier mask level.
// - A routine may lower the mask to allow nesting; return resumes the outer one.
// - Non-maskable and polarity select bits may be frozen; frozen bits ignore writes.
// - Non-maskable select frozen at 0 never acts as NMI; frozen at 1 always does.
// - Polarity frozen at 0 takes falling edges only; frozen at 1 rising only.
// - Halt mode stops every system clock.
// - Standby stops only the CPU clocks; oscillator and watchdog clocks keep running.
// - Idle keeps clocks running and waits for reset or an enabled interrupt.
// - With low power disabled by option, writes to mode selection have no effect.
// - The wait instruction enters halt, standby or idle as the selection says.
// - Up to 24 selectable wakeup sources plus power-module interrupts end low power.
// - A wakeup source counts only when enabled locally and globally.
package islp_pkg;

    // ==========================================================
    // Sizes
    localparam int ISLP_NSRC = 8;
    localparam int ISLP_NWAKE = 24;
    localparam int ISLP_LVLW = 3;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ISLP_OFF_EXT_CTRL = 8'h00;
    localparam logic [7:0] ISLP_OFF_LP_SEL = 8'h04;
    localparam logic [7:0] ISLP_OFF_WAKE_EN = 8'h08;
    localparam logic [7:0] ISLP_OFF_STATUS_WORD = 8'h0C;
    localparam logic [7:0] ISLP_OFF_LEVEL = 8'h10;
    localparam logic [7:0] ISLP_OFF_EV_STAT = 8'h14;
    localparam logic [7:0] ISLP_OFF_EV_MASK = 8'h18;
    localparam logic [7:0] ISLP_OFF_CORE_STATE = 8'h1C;

    // ==========================================================
    // Field positions
    localparam int ISLP_EXT_EN_BIT = 0;
    localparam int ISLP_EXT_EDGE_BIT = 2;
    localparam int ISLP_EXT_NMI_BIT = 5;
    localparam int ISLP_SW_GIE_BIT = 4;
    localparam int ISLP_EV_EDGE = 0;
    localparam int ISLP_EV_WAKE = 1;
    localparam int ISLP_EV_OVFL = 2;
    localparam int ISLP_EV_PHANTOM = 3;
    localparam int ISLP_EV_NMI_HELD = 4;
    localparam int ISLP_NEV = 5;

    // ==========================================================
    // Reset values
    localparam logic [2:0] ISLP_MASK_ALL = 3'h7;
    localparam logic [2:0] ISLP_RST_MASK = 3'h7;
    localparam logic [1:0] ISLP_RST_LP_SEL = 2'h0;
    localparam logic [23:0] ISLP_RST_LEVEL = 24'h00_0000;

    // ==========================================================
    // Low-power selection codes and power states
    localparam logic [1:0] ISLP_SEL_IDLE = 2'h0;
    localparam logic [1:0] ISLP_SEL_STANDBY = 2'h1;
    localparam logic [1:0] ISLP_SEL_HALT = 2'h2;

    typedef enum logic [2:0] {
        ISLP_PM_RUN = 3'b000,
        ISLP_PM_IDLE = 3'b001,
        ISLP_PM_STANDBY = 3'b010,
        ISLP_PM_HALT = 3'b011,
        ISLP_PM_WAKE = 3'b100
    } islp_pmode_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } islp_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } islp_apb_rsp_t;

    typedef struct packed {
        logic req;
        logic nmi;
        logic [2:0] id;
    } islp_offer_t;

    typedef struct packed {
        logic sys;
        logic cpu;
        logic osc;
        logic wdt;
    } islp_clk_en_t;

    // Saved status word: NMI-in-service flag, global enable, mask level
    typedef struct packed {
        logic nmi_act;
        logic gie;
        logic [2:0] mask;
    } islp_saved_t;

endpackage : islp_pkg

/* File: rtl/islp_pin_edge.sv */
// Pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module islp_pin_edge (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // Pin
    input wire logic i_pin,
    // Edge pulses
    output logic o_rise,
    output logic o_fall
);
    logic [2:0] sync;
    logic level;
    logic primed;

    // The first stage feeds only the second; edges come from stages two and three
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync <= 3'h0;
            level <= 1'b0;
            primed <= 1'b0;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end else if (i_ce) begin
            sync <= {sync[1:0], i_pin};
            o_rise <= 1'b0;
            o_fall <= 1'b0;
            if (sync[1] == sync[2]) begin
                primed <= 1'b1;
                level <= sync[2];
                // First agreement only loads the level, which is the reset zero, so a pin high from reset still gives a rise
                if (primed && sync[2] != level) begin
                    o_rise <= sync[2];
                    o_fall <= ~sync[2];
                end
            end
        end
    end
endmodule : islp_pin_edge

/* File: rtl/islp_core.sv */
// Interrupt arbitration, status-word stack, Type A pin and low-power control
`timescale 1ns/1ps
module islp_core
    import islp_pkg::*;
#(
    parameter int STACK_DEPTH = 8,
    parameter int NPM = 7,
    parameter bit FREEZE_NMI = 1'b0,
    parameter bit FREEZE_NMI_VAL = 1'b0,
    parameter bit FREEZE_POL = 1'b0,
    parameter bit FREEZE_POL_VAL = 1'b0,
    parameter bit LP_DISABLE = 1'b0
) (
    // Clock, reset, clock enable
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // APB slave
    input wire islp_apb_req_t i_apb,
    output islp_apb_rsp_t o_apb,
    // Request sources
    input wire logic [ISLP_NSRC-2:0] i_irq_req,
    input wire logic i_ext_pin,
    input wire logic [ISLP_NWAKE-1:0] i_wake_src,
    input wire logic [NPM-1:0] i_pm_irq,
    // CPU side
    input wire logic i_cpu_ack,
    input wire logic i_cpu_rti,
    input wire logic i_cpu_wait,
    output islp_offer_t o_offer,
    output logic [2:0] o_mask_level,
    output logic o_cpu_idle,
    // Clock gates and interrupt
    output islp_clk_en_t o_clk_en,
    output logic o_irq
);
    localparam int SPW = $clog2(STACK_DEPTH + 1);
    localparam logic [SPW-1:0] SP_FULL = SPW'(STACK_DEPTH);
    localparam logic [SPW-1:0] SP_ONE = SPW'(1);

    typedef struct packed {
        islp_apb_rsp_t apb;
        logic ext_nmi_sel;
        logic ext_edge_sel;
        logic ext_en;
        logic [1:0] lp_sel;
        logic [ISLP_NWAKE-1:0] wake_en;
        logic [ISLP_NSRC*ISLP_LVLW-1:0] level;
        islp_saved_t sw;
        logic ext_pend;
        logic nmi_pend;
        logic [ISLP_NEV-1:0] ev_stat;
        logic [ISLP_NEV-1:0] ev_mask;
        logic [STACK_DEPTH-1:0][4:0] stk;
        logic [SPW-1:0] sp;
        islp_pmode_t pmode;
        islp_offer_t offer;
        islp_clk_en_t clk;
        logic idle;
        logic irq;
    } islp_state_t;

    islp_state_t s;
    islp_state_t next_s;
    logic edge_rise;
    logic edge_fall;

    islp_pin_edge u_pin (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_pin(i_ext_pin),
        .o_rise(edge_rise),
        .o_fall(edge_fall)
    );

    // ==========================================================
    // Effective Type A selections
    logic nmi_sel;
    logic pol_sel;
    assign nmi_sel = FREEZE_NMI ? FREEZE_NMI_VAL : s.ext_nmi_sel;
    assign pol_sel = FREEZE_POL ? FREEZE_POL_VAL : s.ext_edge_sel;

    // ==========================================================
    // Arbitration
    logic [ISLP_NSRC-1:0] pend;
    logic found;
    logic [2:0] best_id;
    logic [2:0] best_lvl;
    logic nmi_ok;
    logic wake_lp;

    always_comb begin
        logic [2:0] lvl;
        lvl = 3'h0;
        pend = {i_irq_req, s.ext_pend & s.ext_en & ~nmi_sel};
        found = 1'b0;
        best_id = 3'h0;
        best_lvl = 3'h0;
        // Walk from the chain's tail so the position nearest the head wins a tie
        for (int i = ISLP_NSRC - 1; i >= 0; i--) begin
            lvl = s.level[i*ISLP_LVLW +: ISLP_LVLW];
            if (pend[i] && s.sw.gie && lvl > s.sw.mask && (!found || lvl >= best_lvl)) begin
                found = 1'b1;
                best_id = 3'(i);
                best_lvl = lvl;
            end
        end
        nmi_ok = s.nmi_pend & ~s.sw.nmi_act;
        // Wakeup sources need local and global enable; power-module irqs need only global, NMI neither
        wake_lp = (s.sw.gie & ((|(i_wake_src & s.wake_en)) | (|i_pm_irq))) | nmi_ok;
    end

    // ==========================================================
    // Register read mux
    function automatic logic [31:0] rd_mux(input islp_state_t st, input logic [7:0] a,
                                           input logic nsel, input logic psel_v);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            ISLP_OFF_EXT_CTRL: begin
                d[ISLP_EXT_EN_BIT] = st.ext_en;
                d[ISLP_EXT_EDGE_BIT] = psel_v;
                d[ISLP_EXT_NMI_BIT] = nsel;
            end
            ISLP_OFF_LP_SEL: d[1:0] = st.lp_sel;
            ISLP_OFF_WAKE_EN: d[ISLP_NWAKE-1:0] = st.wake_en;
            ISLP_OFF_STATUS_WORD: begin
                d[2:0] = st.sw.mask;
                d[ISLP_SW_GIE_BIT] = st.sw.gie;
            end
            ISLP_OFF_LEVEL: d[ISLP_NSRC*ISLP_LVLW-1:0] = st.level;
            ISLP_OFF_EV_STAT: d[ISLP_NEV-1:0] = st.ev_stat;
            ISLP_OFF_EV_MASK: d[ISLP_NEV-1:0] = st.ev_mask;
            ISLP_OFF_CORE_STATE: begin
                d[7:0] = 8'(st.sp);
                d[8] = st.sw.nmi_act;
                d[9] = st.nmi_pend;
                d[10] = st.ext_pend;
                d[14:12] = st.pmode;
            end
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction : rd_mux

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= ISLP_OFF_CORE_STATE);
    endfunction : mapped

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic wr;
        logic sel_edge;
        logic wake;
        islp_saved_t top;
        next_s = s;
        wr = 1'b0;
        top = '0;
        sel_edge = pol_sel ? edge_rise : edge_fall;
        wake = 1'b0;
        // APB: one wait state; the write lands on the edge that sees pready high
        next_s.apb.pready = 1'b0;
        next_s.apb.pslverr = 1'b0;
        if (i_apb.psel && i_apb.penable && !s.apb.pready) begin
            next_s.apb.pready = 1'b1;
            next_s.apb.pslverr = ~mapped(i_apb.paddr);
            next_s.apb.prdata = i_apb.pwrite ? 32'h0000_0000 :
                                rd_mux(s, i_apb.paddr, nmi_sel, pol_sel);
        end
        wr = i_apb.psel && i_apb.penable && s.apb.pready && i_apb.pwrite;
        if (wr) begin
            case (i_apb.paddr)
                ISLP_OFF_EXT_CTRL: begin
                    next_s.ext_en = i_apb.pwdata[ISLP_EXT_EN_BIT];
                    // Frozen bits read back their fixed value; the stored copy is unused
                    if (!FREEZE_NMI) begin
                        next_s.ext_nmi_sel = i_apb.pwdata[ISLP_EXT_NMI_BIT];
                    end
                    if (!FREEZE_POL) begin
                        next_s.ext_edge_sel = i_apb.pwdata[ISLP_EXT_EDGE_BIT];
                    end
                end
                ISLP_OFF_LP_SEL: begin
                    if (!LP_DISABLE) begin
                        next_s.lp_sel = i_apb.pwdata[1:0];
                    end
                end
                ISLP_OFF_WAKE_EN: next_s.wake_en = i_apb.pwdata[ISLP_NWAKE-1:0];
                ISLP_OFF_STATUS_WORD: begin
                    next_s.sw.mask = i_apb.pwdata[2:0];
                    next_s.sw.gie = i_apb.pwdata[ISLP_SW_GIE_BIT];
                end
                ISLP_OFF_LEVEL: next_s.level = i_apb.pwdata[ISLP_NSRC*ISLP_LVLW-1:0];
                ISLP_OFF_EV_STAT: next_s.ev_stat = s.ev_stat & ~i_apb.pwdata[ISLP_NEV-1:0];
                ISLP_OFF_EV_MASK: next_s.ev_mask = i_apb.pwdata[ISLP_NEV-1:0];
                default: next_s.ev_mask = next_s.ev_mask;
            endcase
        end

        // Interrupt entry: save status word, raise mask to all ones
        if (i_cpu_ack && s.pmode == ISLP_PM_RUN) begin
            if (s.offer.req) begin
                if (s.sp == SP_FULL) begin
                    // No room to save: entry still proceeds, return will not restore
                    next_s.ev_stat[ISLP_EV_OVFL] = 1'b1;
                end else begin
                    next_s.stk[s.sp] = s.sw;
                    next_s.sp = s.sp + SP_ONE;
                end
                next_s.sw.mask = ISLP_MASK_ALL;
                if (s.offer.nmi) begin
                    next_s.sw.nmi_act = 1'b1;
                    next_s.nmi_pend = 1'b0;
                end else if (s.offer.id == 3'h0) begin
                    next_s.ext_pend = 1'b0;
                end
            end else begin
                next_s.ev_stat[ISLP_EV_PHANTOM] = 1'b1;
            end
        end else if (i_cpu_rti && s.sp != SPW'(0)) begin
            // Pop restores mask, global enable and NMI-in-service to the outer routine
            top = s.stk[s.sp - SP_ONE];
            next_s.sw = top;
            next_s.sp = s.sp - SP_ONE;
        end

        // Type A edge: set wins over any clear in the same cycle
        if (sel_edge) begin
            next_s.ev_stat[ISLP_EV_EDGE] = 1'b1;
            if (nmi_sel) begin
                next_s.nmi_pend = 1'b1;
                if (s.sw.nmi_act) begin
                    next_s.ev_stat[ISLP_EV_NMI_HELD] = 1'b1;
                end
            end else begin
                next_s.ext_pend = 1'b1;
            end
        end

        // Power-mode sequence
        case (s.pmode)
            ISLP_PM_RUN: begin
                if (i_cpu_wait && !(i_cpu_ack && s.offer.req)) begin
                    case (s.lp_sel)
                        ISLP_SEL_HALT: begin
                            next_s.pmode = ISLP_PM_HALT;
                            next_s.clk = '0;
                        end
                        ISLP_SEL_STANDBY: begin
                            next_s.pmode = ISLP_PM_STANDBY;
                            next_s.clk = '{sys: 1'b1, cpu: 1'b0, osc: 1'b1, wdt: 1'b1};
                        end
                        default: begin
                            next_s.pmode = ISLP_PM_IDLE;
                            next_s.idle = 1'b1;
                        end
                    endcase
                end
            end
            ISLP_PM_IDLE: wake = wake_lp | found;
            ISLP_PM_STANDBY: wake = wake_lp;
            ISLP_PM_HALT: wake = wake_lp;
            ISLP_PM_WAKE: begin
                next_s.pmode = ISLP_PM_RUN;
                next_s.idle = 1'b0;
            end
            default: next_s.pmode = ISLP_PM_RUN;
        endcase
        if (wake) begin
            // Clocks return two cycles ahead of the CPU being offered any request
            next_s.pmode = ISLP_PM_WAKE;
            next_s.clk = '{sys: 1'b1, cpu: 1'b1, osc: 1'b1, wdt: 1'b1};
            next_s.ev_stat[ISLP_EV_WAKE] = 1'b1;
        end

        // Offer to the CPU, withheld outside run and on the cycle it is taken
        next_s.offer = '0;
        if (next_s.pmode == ISLP_PM_RUN && s.pmode == ISLP_PM_RUN && !i_cpu_ack) begin
            next_s.offer.req = nmi_ok | found;
            next_s.offer.nmi = nmi_ok;
            next_s.offer.id = nmi_ok ? 3'h0 : best_id;
        end
        next_s.irq = |(next_s.ev_stat & next_s.ev_mask);
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s <= '0;
            s.sw.mask <= ISLP_RST_MASK;
            s.lp_sel <= ISLP_RST_LP_SEL;
            s.level <= ISLP_RST_LEVEL;
            s.pmode <= ISLP_PM_RUN;
            s.clk <= '{sys: 1'b1, cpu: 1'b1, osc: 1'b1, wdt: 1'b1};
        end else if (i_ce) begin
            s <= next_s;
        end
    end

    assign o_apb = s.apb;
    assign o_offer = s.offer;
    assign o_mask_level = s.sw.mask;
    assign o_cpu_idle = s.idle;
    assign o_clk_en = s.clk;
    assign o_irq = s.irq;

endmodule : islp_core

/* File: test/islp_core_properties.sv */
// Port checks for the interrupt service and low-power block
`timescale 1ns/1ps
module islp_core_properties
    import islp_pkg::*;
#(
    parameter int STACK_DEPTH = 8
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Register bus
    input wire islp_apb_req_t i_apb,
    input wire islp_apb_rsp_t o_apb,
    // CPU side
    input wire logic i_cpu_ack,
    input wire logic i_cpu_rti,
    input wire logic i_cpu_wait,
    input wire islp_offer_t o_offer,
    input wire logic [2:0] o_mask_level,
    input wire logic o_cpu_idle,
    input wire islp_clk_en_t o_clk_en
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_sys_rst);

    // ========================================
    // Service entry and return
    logic taken;
    assign taken = i_cpu_ack && o_offer.req && o_clk_en.cpu && !o_cpu_idle;

    a_ack_masks_all:
    assert property (taken |=> o_mask_level == 3'h7 && !o_offer.req)
        else $error("accepted offer left mask or offer unchanged");
    a_mask_blocks:
    assert property (o_mask_level == 3'h7 && $past(o_mask_level) == 3'h7
        |-> !(o_offer.req && !o_offer.nmi)) else $error("maskable offer under full mask");
    a_nmi_blocked:
    assert property (taken && o_offer.nmi ##1 (!i_cpu_rti) [*8]
        |-> !(o_offer.req && o_offer.nmi)) else $error("second NMI offered in NMI service");

    // ========================================
    // Clock gating
    a_halt_all:
    assert property (!o_clk_en.osc |-> o_clk_en == 4'h0) else $error("halt left a clock on");
    a_standby_keep:
    assert property (!o_clk_en.cpu && o_clk_en.osc |-> o_clk_en.sys && o_clk_en.wdt)
        else $error("standby stopped a free clock");
    a_idle_clocks:
    assert property (o_cpu_idle |-> o_clk_en == 4'hF) else $error("idle changed clocks");
    a_wait_cause:
    assert property ($fell(o_clk_en.cpu) |-> $past(i_cpu_wait))
        else $error("CPU clock stopped without wait");
    a_wake_quiet:
    assert property ($rose(o_clk_en.cpu) |-> !o_offer.req ##1 !o_offer.req)
        else $error("offer before clocks settled");

    // ========================================
    // Bus answer timing
    a_apb_wait:
    assert property (i_apb.psel && i_apb.penable && !o_apb.pready |=> o_apb.pready)
        else $error("bus answer not after one wait state");
    a_apb_refuse:
    assert property (i_apb.psel && i_apb.penable && !o_apb.pready && !i_apb.pwrite
        && i_apb.paddr > 8'h1C |=> o_apb.pslverr && o_apb.prdata == 32'h0000_0000)
        else $error("unmapped read not refused");
endmodule : islp_core_properties

bind islp_core islp_core_properties #(.STACK_DEPTH(STACK_DEPTH)) chk_u (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_apb(i_apb), .o_apb(o_apb),
    .i_cpu_ack(i_cpu_ack), .i_cpu_rti(i_cpu_rti), .i_cpu_wait(i_cpu_wait),
    .o_offer(o_offer), .o_mask_level(o_mask_level), .o_cpu_idle(o_cpu_idle),
    .o_clk_en(o_clk_en)
);

/* File: test/islp_periph_model.sv */
// Peripheral request sources that hold a request until it is accepted
`timescale 1ns/1ps
module islp_periph_model
    import islp_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Raise strobes and CPU acceptance
    input wire logic [ISLP_NSRC-2:0] i_raise,
    input wire islp_offer_t i_offer,
    input wire logic i_ack,
    // Request lines
    output logic [ISLP_NSRC-2:0] o_irq_req
);
    // ========================================
    // A request stays up until its own offer is taken, like a real flag
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_irq_req <= '0;
        end else begin
            for (int k = 1; k < ISLP_NSRC; k++) begin
                if (i_raise[k-1])
                    o_irq_req[k-1] <= 1'b1;
                else if (i_ack && i_offer.req && !i_offer.nmi && i_offer.id == k)
                    o_irq_req[k-1] <= 1'b0;
            end
        end
    end
endmodule : islp_periph_model

/* File: test/islp_core_bench.sv */
// Self-checking bench for the interrupt service and low-power block
`timescale 1ns/1ps
module islp_core_bench import islp_pkg::*;;
    // ========================================
    // Signals
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    islp_apb_req_t apb = '0;
    islp_apb_rsp_t rsp, rsp_f;
    logic [6:0] raise = '0;
    logic [6:0] irq_req;
    logic ext_pin = 1'b0;
    logic ce = 1'b1;
    logic [23:0] wake_src = '0;
    logic [6:0] pm_irq = '0;
    logic [2:0] cpu = '0;
    islp_offer_t offer, offer_f;
    logic [2:0] mask;
    logic idle, irq;
    islp_clk_en_t clk_en;
    logic [31:0] rq, rqf;
    logic re;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [4:0] sleep_exp [3] = '{5'b0000_0, 5'b1011_0, 5'b1111_1};
    logic [1:0] sel [3] = '{ISLP_SEL_HALT, ISLP_SEL_STANDBY, ISLP_SEL_IDLE};
    logic [23:0] wv [3] = '{24'h80_0000, 24'h00_0001, 24'h00_0000};

    always #2.5 i_mclk = ~i_mclk;

    islp_core dut_u (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(ce), .i_apb(apb), .o_apb(rsp),
        .i_irq_req(irq_req), .i_ext_pin(ext_pin), .i_wake_src(wake_src), .i_pm_irq(pm_irq),
        .i_cpu_ack(cpu[0]), .i_cpu_rti(cpu[1]), .i_cpu_wait(cpu[2]), .o_offer(offer),
        .o_mask_level(mask), .o_cpu_idle(idle), .o_clk_en(clk_en), .o_irq(irq));
    // Frozen variant: NMI select held at 1, falling edge only, low power disabled
    islp_core #(.FREEZE_NMI(1'b1), .FREEZE_NMI_VAL(1'b1), .FREEZE_POL(1'b1),
        .FREEZE_POL_VAL(1'b0), .LP_DISABLE(1'b1)) dut_f_u (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(ce), .i_apb(apb), .o_apb(rsp_f),
        .i_irq_req(irq_req), .i_ext_pin(ext_pin), .i_wake_src(wake_src), .i_pm_irq(pm_irq),
        .i_cpu_ack(cpu[0]), .i_cpu_rti(cpu[1]), .i_cpu_wait(cpu[2]), .o_offer(offer_f),
        .o_mask_level(), .o_cpu_idle(), .o_clk_en(), .o_irq());
    islp_periph_model periph_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_raise(raise),
        .i_offer(offer), .i_ack(cpu[0]), .o_irq_req(irq_req));

    // ========================================
    // Tasks
    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : cyc

    // Request held until pready is sampled high; the answer is taken at that edge
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge i_mclk);
        apb.penable <= 1'b1;
        do begin
            @(posedge i_mclk);
        end while (rsp.pready !== 1'b1);
        rq = rsp.prdata;
        rqf = rsp_f.prdata;
        re = rsp.pslverr;
        apb <= '0;
    endtask : xf

    // Bits of p: 0 accept, 1 return, 2 wait
    task automatic pulse(input logic [2:0] p);
        @(posedge i_mclk);
        cpu <= p;
        @(posedge i_mclk);
        cpu <= '0;
    endtask : pulse

    task automatic wait_offer(input logic nmi, input logic [2:0] id);
        int n;
        n = 0;
        while (offer.req !== 1'b1 && n < 60) begin
            n++;
            @(posedge i_mclk);
        end
        chk("offer", {offer.req, offer.nmi, offer.id}, {1'b1, nmi, id});
    endtask : wait_offer

    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ========================================
    // Sequence
    initial begin
        repeat (6) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        xf(0, ISLP_OFF_STATUS_WORD, 0);
        chk("status reset", rq, 32'h0000_0007);
        xf(0, 8'h20, 0);
        chk("unmapped err", {31'h0, re}, 1);
        chk("unmapped data", rq, 0);
        // Sources 1..3 at levels 3, 5, 5: tie broken by chain position
        xf(1, ISLP_OFF_LEVEL, 32'h0000_0B58);
        @(posedge i_mclk);
        raise <= 7'h07;
        @(posedge i_mclk);
        raise <= '0;
        xf(1, ISLP_OFF_STATUS_WORD, 32'h0000_0010);
        wait_offer(0, 3'd2);
        pulse(3'b001);
        cyc(1);
        chk("mask on entry", mask, 7);
        chk("offer dropped", offer.req, 0);
        xf(1, ISLP_OFF_STATUS_WORD, 32'h0000_0014);
        wait_offer(0, 3'd3);
        pulse(3'b001);
        pulse(3'b010);
        cyc(1);
        chk("mask nested return", mask, 4);
        pulse(3'b010);
        cyc(1);
        chk("mask outer return", mask, 0);
        wait_offer(0, 3'd1);
        pulse(3'b001);
        pulse(3'b010);
        // Type A pin: writable versus frozen select bits
        xf(1, ISLP_OFF_EV_STAT, 32'h0000_001F);
        xf(1, ISLP_OFF_EXT_CTRL, 32'h0000_0005);
        xf(0, ISLP_OFF_EXT_CTRL, 0);
        chk("ext ctrl", rq, 32'h0000_0005);
        chk("ext ctrl frozen", rqf, 32'h0000_0021);
        ext_pin <= 1'b1;
        cyc(12);
        xf(0, ISLP_OFF_EV_STAT, 0);
        chk("rise edge", rq[0], 1);
        chk("rise edge frozen", rqf[0], 0);
        ext_pin <= 1'b0;
        cyc(12);
        xf(0, ISLP_OFF_EV_STAT, 0);
        chk("fall edge frozen", rqf[0], 1);
        chk("frozen nmi offer", {offer_f.req, offer_f.nmi}, 2'b11);
        chk("maskable pin offer", offer.req, 0);
        // NMI under full mask, then a second NMI edge during its service
        xf(1, ISLP_OFF_STATUS_WORD, 32'h0000_0017);
        xf(1, ISLP_OFF_EXT_CTRL, 32'h0000_0025);
        ext_pin <= 1'b1;
        wait_offer(1, 3'd0);
        pulse(3'b001);
        ext_pin <= 1'b0;
        cyc(8);
        ext_pin <= 1'b1;
        cyc(14);
        chk("nmi blocked", offer.req, 0);
        xf(0, ISLP_OFF_EV_STAT, 0);
        chk("nmi in service event", rq[4], 1);
        pulse(3'b010);
        cyc(1);
        chk("mask after nmi return", mask, 7);
        xf(1, ISLP_OFF_EXT_CTRL, 0);
        wait_offer(1, 3'd0);
        pulse(3'b001);
        pulse(3'b010);
        // Low power: halt, standby, idle; global then local enable before waking
        xf(1, ISLP_OFF_WAKE_EN, 32'h0080_0001);
        ce <= 1'b0;
        pulse(3'b100);
        ce <= 1'b1;
        cyc(1);
        chk("frozen by enable", {clk_en, idle}, 5'b1111_0);
        for (int r = 0; r < 3; r++) begin
            xf(1, ISLP_OFF_LP_SEL, {30'h0, sel[r]});
            xf(0, ISLP_OFF_LP_SEL, 0);
            chk("lp sel frozen", rqf, 0);
            xf(1, ISLP_OFF_STATUS_WORD, 32'h0000_0007);
            pulse(3'b100);
            cyc(1);
            chk("sleep clocks", {clk_en, idle}, sleep_exp[r]);
            wake_src <= wv[r];
            pm_irq <= {6'h0, r == 2};
            cyc(6);
            chk("global off", {clk_en, idle}, sleep_exp[r]);
            wake_src <= 24'h00_0002;
            pm_irq <= '0;
            xf(1, ISLP_OFF_STATUS_WORD, 32'h0000_0017);
            cyc(6);
            chk("local off", {clk_en, idle}, sleep_exp[r]);
            wake_src <= wv[r] | 24'h00_0002;
            pm_irq <= {6'h0, r == 2};
            cyc(6);
            chk("woken", {clk_en, idle}, 5'b1111_0);
            wake_src <= '0;
            pm_irq <= '0;
        end
        // Interrupt output: masked, unmasked, cleared
        xf(1, ISLP_OFF_EV_MASK, 0);
        xf(0, ISLP_OFF_EV_STAT, 0);
        chk("wake event", rq[1], 1);
        chk("irq masked", irq, 0);
        xf(1, ISLP_OFF_EV_MASK, 32'h0000_0002);
        cyc(2);
        chk("irq raised", irq, 1);
        xf(1, ISLP_OFF_EV_STAT, 32'h0000_0002);
        cyc(2);
        chk("irq cleared", irq, 0);
        end_of_test();
    end
endmodule : islp_core_bench
